// ---- fdc_map.svh ----
// Constants of the frame data word codec: widths, format numbers, codes, steps and limits
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH

// ==========================================================================
// Widths
`define FDC_WORD_W 16
`define FDC_BYTE_W 8
`define FDC_RAW_W 32
`define FDC_FMT_W 7
`define FDC_CODE_W 7
`define FDC_PROTO_W 2

// ==========================================================================
// Data format numbers
`define FDC_FMT_NONE 7'h00
`define FDC_FMT_UINT 7'h01
`define FDC_FMT_SINT 7'h02
`define FDC_FMT_UDEC1 7'h03
`define FDC_FMT_SDEC1 7'h04
`define FDC_FMT_UDEC2 7'h05
`define FDC_FMT_SDEC2 7'h06
`define FDC_FMT_UDEC3 7'h07
`define FDC_FMT_SDEC3 7'h08
`define FDC_FMT_CUR_RTU 7'h13
`define FDC_FMT_FREQ 7'h16
`define FDC_FMT_CUR 7'h18
`define FDC_FMT_POS_UPPER 7'h49
`define FDC_FMT_MOTOR 7'h4A

// ==========================================================================
// Z group codes
`define FDC_ALARM2_OUTPUT_FREQ_CODE 7'h00
`define FDC_ALARM2_OUTPUT_CUR_CODE 7'h01
`define FDC_MOTOR1_RUNTIME_CODE 7'h28
`define FDC_MOTOR_RUNTIME_N 7'h04
`define FDC_MOTOR2_START_COUNT_CODE 7'h2C
`define FDC_MOTOR_START_N 7'h03
`define FDC_ALARM3_OUTPUT_FREQ_CODE 7'h32
`define FDC_ALARM3_OUTPUT_CUR_CODE 7'h33
`define FDC_CURRENT_POS_UPPER_CODE 7'h5A
`define FDC_STOP_POS_UPPER_CODE 7'h5C
`define FDC_POS_DIFF_UPPER_CODE 7'h5E
`define FDC_POS_LOWER_OFS 7'h01

// ==========================================================================
// Protocol paths
`define FDC_PROTO_NATIVE 2'h0
`define FDC_PROTO_RTU 2'h1
`define FDC_PROTO_BUS 2'h2

// ==========================================================================
// Raw values are in thousandths of a unit; divisor per step size
`define FDC_DIV_STEP1 32'h000003E8
`define FDC_DIV_STEP01 32'h00000064
`define FDC_DIV_STEP001 32'h0000000A
`define FDC_DIV_STEP0001 32'h00000001

// ==========================================================================
// Word limits
`define FDC_UINT_MIN 16'h0000
`define FDC_UINT_MAX 16'hFFFF
`define FDC_SINT_MAX 16'h7FFF
`define FDC_SINT_MIN 16'h8000

`endif

// ---- fdc_pkg.sv ----
// Types of the frame data word codec
`include "fdc_map.svh"

package fdc_pkg;

  // ========================================================================
  // Transmit sequencer
  typedef enum logic [0:0] {
    FDC_TX_IDLE,
    FDC_TX_LOW
  } fdc_tx_e;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic by_code;
    logic [`FDC_CODE_W-1:0] code;
    logic [`FDC_PROTO_W-1:0] proto;
    logic [`FDC_FMT_W-1:0] fmt;
    logic [`FDC_RAW_W-1:0] raw;
  } fdc_req_s;

  typedef struct packed {
    logic valid;
    logic unknown;
    logic [`FDC_FMT_W-1:0] fmt;
    logic [`FDC_WORD_W-1:0] word;
  } fdc_resp_s;

  typedef struct packed {
    logic valid;
    logic [`FDC_BYTE_W-1:0] data;
    logic [`FDC_FMT_W-1:0] fmt;
  } fdc_rx_s;

  typedef struct packed {
    logic valid;
    logic unknown;
    logic [`FDC_FMT_W-1:0] fmt;
    logic [`FDC_WORD_W-1:0] word;
    logic [`FDC_RAW_W-1:0] value;
  } fdc_dec_s;

  typedef struct packed {
    fdc_tx_e tx;
    logic req_ready;
    logic tx_valid;
    logic [`FDC_BYTE_W-1:0] tx_byte;
    logic [`FDC_BYTE_W-1:0] tx_low;
    fdc_resp_s resp;
    logic rx_have_hi;
    logic [`FDC_BYTE_W-1:0] rx_hi;
    fdc_dec_s dec;
  } fdc_state_s;

endpackage : fdc_pkg

// ---- fdc_codec.sv ----
// Frame data word codec: encoder with code lookup, byte serialiser and word decoder
`timescale 1ns/1ps
`include "fdc_map.svh"

// Summary of operation
// - Every data field value is one 16-bit word
// - Upper byte 15..8 goes before lower 7..0
// - Format 1 is unsigned integer, step one
// - Format 2 is two's complement integer, step one
// - Format 3 is unsigned, step one tenth
// - Format 4 is signed, step one tenth
// - Format 5 is unsigned, step one hundredth
// - Format 6 is signed, step one hundredth
// - Format 7 is unsigned, step one thousandth
// - Format 8 is signed, step one thousandth
// - Second-last alarm output frequency uses format 22
// - Third-last alarm output frequency uses format 22
// - Four motor runtime codes use format 74
// - Three motor start count codes use format 74
// - Current position splits upper 73, lower 1
// - Stop position splits upper 73, lower 1
// - Position difference splits upper 73, lower 1
// - Alarm current: 24 native/bus, 19 RTU
module fdc_codec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire fdc_pkg::fdc_req_s req,
  output logic req_ready,
  output fdc_pkg::fdc_resp_s resp,
  output logic tx_valid,
  output logic [`FDC_BYTE_W-1:0] tx_byte,
  input wire fdc_pkg::fdc_rx_s rx,
  output fdc_pkg::fdc_dec_s dec
);

  // ========================================================================
  // Encoding and decoding helpers

  // Upper word of one of the three pulse counts
  function automatic logic is_pos_upper(input logic [`FDC_CODE_W-1:0] code);
    return (code == `FDC_CURRENT_POS_UPPER_CODE) || (code == `FDC_STOP_POS_UPPER_CODE) ||
           (code == `FDC_POS_DIFF_UPPER_CODE);
  endfunction : is_pos_upper

  // Lower word sits on the code just above its upper word
  function automatic logic is_pos_lower(input logic [`FDC_CODE_W-1:0] code);
    return (code >= `FDC_POS_LOWER_OFS) && is_pos_upper(code - `FDC_POS_LOWER_OFS);
  endfunction : is_pos_lower

  // Formats 1 to 8 are the scaled numeric ones
  function automatic logic is_num(input logic [`FDC_FMT_W-1:0] fmt);
    return (fmt >= `FDC_FMT_UINT) && (fmt <= `FDC_FMT_SDEC3);
  endfunction : is_num

  // Even numeric formats are the signed ones
  function automatic logic is_signed_fmt(input logic [`FDC_FMT_W-1:0] fmt);
    return is_num(fmt) && !fmt[0];
  endfunction : is_signed_fmt

  // Formats whose layout is kept as given by the data source
  function automatic logic is_pass(input logic [`FDC_FMT_W-1:0] fmt);
    return (fmt == `FDC_FMT_FREQ) || (fmt == `FDC_FMT_CUR) || (fmt == `FDC_FMT_CUR_RTU) ||
           (fmt == `FDC_FMT_MOTOR) || (fmt == `FDC_FMT_POS_UPPER);
  endfunction : is_pass

  // Thousandths per count for each numeric format
  function automatic logic [`FDC_RAW_W-1:0] step_of(input logic [`FDC_FMT_W-1:0] fmt);
    logic [`FDC_RAW_W-1:0] d;
    case (fmt)
      `FDC_FMT_UINT, `FDC_FMT_SINT: d = `FDC_DIV_STEP1;
      `FDC_FMT_UDEC1, `FDC_FMT_SDEC1: d = `FDC_DIV_STEP01;
      `FDC_FMT_UDEC2, `FDC_FMT_SDEC2: d = `FDC_DIV_STEP001;
      default: d = `FDC_DIV_STEP0001;
    endcase
    return d;
  endfunction : step_of

  // Format number that a Z group code carries on a given protocol path
  function automatic logic [`FDC_FMT_W-1:0] z_format(input logic [`FDC_CODE_W-1:0] code,
                                                     input logic [`FDC_PROTO_W-1:0] proto);
    logic [`FDC_FMT_W-1:0] f;
    f = `FDC_FMT_NONE;
    if (code == `FDC_ALARM2_OUTPUT_FREQ_CODE) begin
      f = `FDC_FMT_FREQ;
    end else if (code == `FDC_ALARM3_OUTPUT_FREQ_CODE) begin
      f = `FDC_FMT_FREQ;
    end else if (code == `FDC_ALARM2_OUTPUT_CUR_CODE || code == `FDC_ALARM3_OUTPUT_CUR_CODE) begin
      f = (proto == `FDC_PROTO_RTU) ? `FDC_FMT_CUR_RTU : `FDC_FMT_CUR;
    end else if (code >= `FDC_MOTOR1_RUNTIME_CODE &&
                 code < `FDC_MOTOR1_RUNTIME_CODE + `FDC_MOTOR_RUNTIME_N) begin
      f = `FDC_FMT_MOTOR;
    end else if (code >= `FDC_MOTOR2_START_COUNT_CODE &&
                 code < `FDC_MOTOR2_START_COUNT_CODE + `FDC_MOTOR_START_N) begin
      f = `FDC_FMT_MOTOR;
    end else if (is_pos_upper(code)) begin
      f = `FDC_FMT_POS_UPPER;
    end else if (is_pos_lower(code)) begin
      f = `FDC_FMT_UINT;
    end
    return f;
  endfunction : z_format

  // Scale thousandths into one word, rounding half away from zero
  function automatic logic [`FDC_WORD_W-1:0] enc_scaled(input logic [`FDC_RAW_W-1:0] raw,
                                                       input logic [`FDC_RAW_W-1:0] div,
                                                       input logic sgn);
    logic neg;
    logic [`FDC_RAW_W:0] mag;
    logic [`FDC_RAW_W:0] q;
    logic [`FDC_WORD_W-1:0] w;
    neg = raw[`FDC_RAW_W-1];
    mag = neg ? (33'h000000000 - {raw[`FDC_RAW_W-1], raw}) : {1'b0, raw};
    q = (mag + {2'h0, div[`FDC_RAW_W-1:1]}) / {1'b0, div};
    // Limits stop a large value wrapping into a wrong sign
    if (sgn) begin
      if (neg) begin
        w = (q > {17'h00000, `FDC_SINT_MIN}) ? `FDC_SINT_MIN : 16'(33'h000000000 - q);
      end else begin
        w = (q > {17'h00000, `FDC_SINT_MAX}) ? `FDC_SINT_MAX : q[`FDC_WORD_W-1:0];
      end
    end else begin
      if (neg) begin
        w = `FDC_UINT_MIN;
      end else begin
        w = (q > {17'h00000, `FDC_UINT_MAX}) ? `FDC_UINT_MAX : q[`FDC_WORD_W-1:0];
      end
    end
    return w;
  endfunction : enc_scaled

  // ========================================================================
  // State

  fdc_pkg::fdc_state_s st;
  fdc_pkg::fdc_state_s next_st;
  logic take;
  logic [`FDC_FMT_W-1:0] enc_fmt;
  logic [`FDC_WORD_W-1:0] enc_word;
  logic enc_unknown;
  logic [`FDC_WORD_W-1:0] rx_word;
  logic [`FDC_RAW_W-1:0] rx_ext;

  // A request is taken only while the serialiser can accept a word
  assign take = req.valid && st.req_ready;

  // Outputs come straight from the state register
  assign req_ready = st.req_ready;
  assign resp = st.resp;
  assign tx_valid = st.tx_valid;
  assign tx_byte = st.tx_byte;
  assign dec = st.dec;

  // ========================================================================
  // Encoder path

  // Format and word for the request on the bus this cycle
  always_comb begin
    enc_fmt = req.by_code ? z_format(req.code, req.proto) : req.fmt;
    enc_unknown = 1'b0;
    if (req.by_code && is_pos_upper(req.code)) begin
      enc_word = req.raw[`FDC_RAW_W-1:`FDC_WORD_W];
    end else if (req.by_code && is_pos_lower(req.code)) begin
      enc_word = req.raw[`FDC_WORD_W-1:0];
    end else if (is_num(enc_fmt)) begin
      enc_word = enc_scaled(req.raw, step_of(enc_fmt), is_signed_fmt(enc_fmt));
    end else if (is_pass(enc_fmt)) begin
      enc_word = req.raw[`FDC_WORD_W-1:0];
    end else begin
      enc_word = `FDC_UINT_MIN;
      enc_unknown = 1'b1;
    end
  end

  // ========================================================================
  // Decoder path

  // Received pair forms one word, upper byte first
  assign rx_word = {st.rx_hi, rx.data};
  // Sign extension only for the signed formats
  assign rx_ext = is_signed_fmt(rx.fmt) ? {{16{rx_word[15]}}, rx_word} : {16'h0000, rx_word};

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.resp.valid = 1'b0;
    next_st.dec.valid = 1'b0;
    next_st.tx_valid = 1'b0;
    // Serialiser: upper byte, then lower byte, no gap between words
    case (st.tx)
      fdc_pkg::FDC_TX_IDLE: begin
        if (take) begin
          next_st.resp.valid = 1'b1;
          next_st.resp.unknown = enc_unknown;
          next_st.resp.fmt = enc_fmt;
          next_st.resp.word = enc_word;
          next_st.tx_byte = enc_word[15:8];
          next_st.tx_low = enc_word[7:0];
          next_st.tx_valid = 1'b1;
          next_st.req_ready = 1'b0;
          next_st.tx = fdc_pkg::FDC_TX_LOW;
        end
      end
      fdc_pkg::FDC_TX_LOW: begin
        next_st.tx_byte = st.tx_low;
        next_st.tx_valid = 1'b1;
        next_st.req_ready = 1'b1;
        next_st.tx = fdc_pkg::FDC_TX_IDLE;
      end
      default: begin
        next_st.req_ready = 1'b1;
        next_st.tx = fdc_pkg::FDC_TX_IDLE;
      end
    endcase
    // Deserialiser: a lone upper byte waits for its partner
    if (rx.valid) begin
      if (!st.rx_have_hi) begin
        next_st.rx_hi = rx.data;
        next_st.rx_have_hi = 1'b1;
      end else begin
        next_st.rx_have_hi = 1'b0;
        next_st.dec.valid = 1'b1;
        next_st.dec.fmt = rx.fmt;
        next_st.dec.word = rx_word;
        next_st.dec.unknown = !(is_num(rx.fmt) || is_pass(rx.fmt));
        // Multiply back to thousandths; low bits are right for both signs
        next_st.dec.value = is_num(rx.fmt) ? 32'(rx_ext * step_of(rx.fmt)) : rx_ext;
      end
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.req_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Direct format request with a given format
  function automatic logic dir(input logic [`FDC_FMT_W-1:0] f);
    return !req.by_code && req.fmt == f;
  endfunction : dir

  AST_ONE_WORD_PER_TAKE: assert property (take |=> resp.valid ##1 !resp.valid)
    else $error("taken request did not give exactly one word");
  AST_UPPER_FIRST: assert property (resp.valid |-> tx_valid && tx_byte == resp.word[15:8])
    else $error("upper byte not sent first");
  AST_LOWER_NEXT: assert property (resp.valid |=> tx_valid && tx_byte == $past(resp.word[7:0]) && req_ready)
    else $error("lower byte not sent second");
  // Only a pair that starts on an upper byte forms a word; a running strobe never pairs a lower byte with the next upper
  AST_DEC_PAIR: assert property (rx.valid && !st.rx_have_hi ##1 rx.valid |=>
                                 dec.valid && dec.word == {$past(rx.data, 2), $past(rx.data)})
    else $error("received pair not assembled upper first");
  AST_FMT1: assert property (take && dir(`FDC_FMT_UINT) && req.raw == 32'h00030D40 |=> resp.word == 16'h00C8)
    else $error("format 1 encode wrong");
  AST_FMT2: assert property (take && dir(`FDC_FMT_SINT) && req.raw == 32'hFFFFB1E0 |=> resp.word == 16'hFFEC)
    else $error("format 2 encode wrong");
  AST_FMT3: assert property (take && dir(`FDC_FMT_UDEC1) && req.raw == 32'h000186A0 |=> resp.word == 16'h03E8)
    else $error("format 3 encode wrong");
  AST_FMT4: assert property (take && dir(`FDC_FMT_SDEC1) && req.raw == 32'hFFFFEC78 |=> resp.word == 16'hFFCE)
    else $error("format 4 encode wrong");
  AST_FMT5: assert property (take && dir(`FDC_FMT_UDEC2) && req.raw == 32'h0000C44A |=> resp.word == 16'h13A1)
    else $error("format 5 encode wrong");
  AST_FMT6: assert property (take && dir(`FDC_FMT_SDEC2) && req.raw == 32'hFFFEB27C |=> resp.word == 16'hDEA6)
    else $error("format 6 encode wrong");
  AST_FMT7: assert property (take && dir(`FDC_FMT_UDEC3) && req.raw[31:16] == 16'h0000 |=>
                             resp.word == $past(req.raw[15:0]))
    else $error("format 7 encode wrong");
  AST_FMT8: assert property (take && dir(`FDC_FMT_SDEC3) && req.raw == 32'hFFFFFB2E |=> resp.word == 16'hFB2E)
    else $error("format 8 encode wrong");
  AST_SAT_UNSIGNED: assert property (take && dir(`FDC_FMT_UINT) && !req.raw[31] &&
                                     req.raw >= 32'h03E7FE0C |=> resp.word == `FDC_UINT_MAX)
    else $error("unsigned overflow did not saturate high");
  AST_SAT_UNSIGNED_NEG: assert property (take && dir(`FDC_FMT_UDEC1) && req.raw[31] |=> resp.word == `FDC_UINT_MIN)
    else $error("negative unsigned did not saturate to zero");
  // Anything at or below minus 32767.5 rounds onto the lowest signed word
  AST_SAT_SIGNED: assert property (take && dir(`FDC_FMT_SINT) && req.raw[31] &&
                                   req.raw <= 32'hFE0C01F4 |=> resp.word == `FDC_SINT_MIN)
    else $error("signed underflow did not saturate low");
  AST_SAT_SIGNED_HIGH: assert property (take && dir(`FDC_FMT_SINT) && !req.raw[31] &&
                                        req.raw >= 32'h01F3FE0C |=> resp.word == `FDC_SINT_MAX)
    else $error("signed overflow did not saturate high");
  AST_ROUND_UP: assert property (take && dir(`FDC_FMT_UDEC1) && req.raw == 32'h00000096 |=> resp.word == 16'h0002)
    else $error("half step did not round up");
  AST_ROUND_DOWN: assert property (take && dir(`FDC_FMT_UDEC1) && req.raw == 32'h00000095 |=> resp.word == 16'h0001)
    else $error("below half step did not round down");
  AST_ALARM2_FREQ: assert property (take && req.by_code && req.code == `FDC_ALARM2_OUTPUT_FREQ_CODE |=>
                                    resp.fmt == `FDC_FMT_FREQ)
    else $error("second-last alarm frequency format wrong");
  AST_ALARM3_FREQ: assert property (take && req.by_code && req.code == `FDC_ALARM3_OUTPUT_FREQ_CODE |=>
                                    resp.fmt == `FDC_FMT_FREQ)
    else $error("third-last alarm frequency format wrong");
  AST_RUNTIME: assert property (take && req.by_code && req.code >= `FDC_MOTOR1_RUNTIME_CODE &&
                                req.code < `FDC_MOTOR2_START_COUNT_CODE |=> resp.fmt == `FDC_FMT_MOTOR)
    else $error("motor runtime format wrong");
  AST_STARTS: assert property (take && req.by_code && req.code >= `FDC_MOTOR2_START_COUNT_CODE &&
                               req.code < `FDC_MOTOR2_START_COUNT_CODE + `FDC_MOTOR_START_N |=>
                               resp.fmt == `FDC_FMT_MOTOR)
    else $error("motor start count format wrong");
  AST_CUR_POS: assert property (take && req.by_code && req.code == `FDC_CURRENT_POS_UPPER_CODE |=>
                                resp.fmt == `FDC_FMT_POS_UPPER && resp.word == $past(req.raw[31:16]))
    else $error("current position upper word wrong");
  AST_STOP_POS: assert property (take && req.by_code &&
                                 req.code == `FDC_STOP_POS_UPPER_CODE + `FDC_POS_LOWER_OFS |=>
                                 resp.fmt == `FDC_FMT_UINT && resp.word == $past(req.raw[15:0]))
    else $error("stop position lower word wrong");
  AST_DIFF_POS: assert property (take && req.by_code && req.code == `FDC_POS_DIFF_UPPER_CODE |=>
                                 resp.fmt == `FDC_FMT_POS_UPPER)
    else $error("position difference upper format wrong");
  AST_ALARM_CUR: assert property (take && req.by_code && req.code == `FDC_ALARM2_OUTPUT_CUR_CODE |=>
                                  resp.fmt == (($past(req.proto) == `FDC_PROTO_RTU) ? `FDC_FMT_CUR_RTU : `FDC_FMT_CUR))
    else $error("alarm current format wrong for protocol");
  // Decoded values come back in thousandths, so format 2 is the signed word times a thousand
  AST_DEC_SIGNED: assert property (dec.valid && dec.fmt == `FDC_FMT_SINT |->
                                   dec.value == 32'({{16{dec.word[15]}}, dec.word} * `FDC_DIV_STEP1))
    else $error("format 2 decode wrong");
  AST_DEC_FMT8: assert property (dec.valid && dec.fmt == `FDC_FMT_SDEC3 |->
                                 dec.value == {{16{dec.word[15]}}, dec.word})
    else $error("format 8 decode wrong");
  AST_DEC_FMT5: assert property (dec.valid && dec.fmt == `FDC_FMT_UDEC2 |->
                                 dec.value == 32'({16'h0000, dec.word} * `FDC_DIV_STEP001))
    else $error("format 5 decode wrong");
  // Ready falls only for the upper byte cycle, which is what keeps takes two edges apart
  AST_READY_GAP: assert property (take |=> !req_ready ##1 req_ready)
    else $error("ready gap after a take is not one cycle");
  // An unsupported format or code must never leak raw bits onto the link
  AST_UNKNOWN_ZERO: assert property (resp.valid && resp.unknown |-> resp.word == `FDC_UINT_MIN)
    else $error("unknown request gave a nonzero word");

  // Main scenarios
  COV_BACK_TO_BACK: cover property (take ##2 take);
  COV_SIGNED_SAT: cover property (take && dir(`FDC_FMT_SDEC2) && req.raw[31] ##1 resp.word == `FDC_SINT_MIN);
  COV_POS_PAIR: cover property (take && req.by_code && is_pos_upper(req.code) ##2
                                take && req.by_code && is_pos_lower(req.code));
  COV_DECODE: cover property (dec.valid && is_signed_fmt(dec.fmt) && dec.word[15]);

endmodule : fdc_codec

// ---- fdc_host_model.sv ----
// Host side model: rebuilds 16-bit words from the codec byte stream
`timescale 1ns/1ps
`include "fdc_map.svh"

module fdc_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [`FDC_BYTE_W-1:0] tx_byte,
  output logic [`FDC_WORD_W-1:0] host_word,
  output logic [7:0] host_cnt
);
  logic have_hi;
  logic [`FDC_BYTE_W-1:0] hi;

  // ==========================================================================
  // Word assembly
  // First byte of each pair is the upper one; no resync, as on the real link
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      have_hi <= 1'b0;
      hi <= 8'h00;
      host_word <= 16'h0000;
      host_cnt <= 8'h00;
    end else if (tx_valid) begin
      if (have_hi) begin
        host_word <= {hi, tx_byte};
        host_cnt <= host_cnt + 8'h01;
      end else begin
        hi <= tx_byte;
      end
      have_hi <= !have_hi;
    end
  end
endmodule : fdc_host_model

// ---- frame_data_word_codec_tb_top.sv ----
// Self-checking testbench of the frame data word codec
`timescale 1ns/1ps
`include "fdc_map.svh"

module frame_data_word_codec_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  fdc_pkg::fdc_req_s req = '0;
  fdc_pkg::fdc_rx_s rx = '0;
  logic req_ready;
  fdc_pkg::fdc_resp_s resp;
  logic tx_valid;
  logic [`FDC_BYTE_W-1:0] tx_byte;
  fdc_pkg::fdc_dec_s dec;
  logic [`FDC_WORD_W-1:0] host_word;
  logic [7:0] host_cnt;
  int n_mismatch = 0;
  int cmp_count = 0;

  // ==========================================================================
  // Clock and instances
  always #20 sys_clk = ~sys_clk;

  fdc_codec fdc_codec_inst (.sys_clk(sys_clk), .rst(rst), .req(req), .req_ready(req_ready), .resp(resp),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .rx(rx), .dec(dec));
  fdc_host_model fdc_host_model_inst (.sys_clk(sys_clk), .rst(rst), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .host_word(host_word), .host_cnt(host_cnt));

  // ==========================================================================
  // Common tasks
  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // One encode request; the word is judged on resp, on the byte stream and at the host
  task automatic enc(input logic bc, input logic [6:0] code, input logic [1:0] pr, input logic [6:0] fmt,
                     input logic [31:0] raw, input logic [6:0] xf, input logic [15:0] xw);
    int i;
    logic [7:0] cnt;
    i = 0;
    // Bounded wait for a free slot; a stuck ready ends the run
    while (req_ready !== 1'b1) begin
      @(negedge sys_clk);
      i++;
      if (i > 8) begin
        n_mismatch++;
        report_and_stop();
      end
    end
    cnt = host_cnt;
    req = '{1'b1, bc, code, pr, fmt, raw};
    @(negedge sys_clk);
    req.valid = 1'b0;
    check({31'h0, resp.valid}, 32'h1);
    check({31'h0, resp.unknown}, {31'h0, xf == `FDC_FMT_NONE});
    if (xf != `FDC_FMT_NONE) check({25'h0, resp.fmt}, {25'h0, xf});
    check({16'h0, resp.word}, {16'h0, xw});
    check({23'h0, tx_valid, tx_byte}, {23'h1, xw[15:8]});
    @(negedge sys_clk);
    check({31'h0, resp.valid}, 32'h0);
    check({23'h0, tx_valid, tx_byte}, {23'h1, xw[7:0]});
    @(negedge sys_clk);
    check({16'h0, host_word}, {16'h0, xw});
    check({24'h0, host_cnt}, {24'h0, cnt + 8'h01});
  endtask : enc

  // One word into the decoder; strobe stays up so words can follow back to back, one every two cycles
  task automatic dcd(input logic [15:0] w, input logic [6:0] f, input logic [31:0] xv, input logic xu);
    rx.valid = 1'b1;
    rx.data = w[15:8];
    @(negedge sys_clk);
    rx.data = w[7:0];
    rx.fmt = f;
    @(negedge sys_clk);
    check({31'h0, dec.valid}, 32'h1);
    check({16'h0, dec.word}, {16'h0, w});
    check(dec.value, xv);
    check({31'h0, dec.unknown}, {31'h0, xu});
  endtask : dcd

  // ==========================================================================
  // Scenarios
  task automatic t_int();
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UINT, 32'h00030D40, `FDC_FMT_UINT, 16'h00C8);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SINT, 32'hFFFFB1E0, `FDC_FMT_SINT, 16'hFFEC);
  endtask : t_int

  task automatic t_fixed();
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UDEC1, 32'h000186A0, `FDC_FMT_UDEC1, 16'h03E8);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SDEC1, 32'hFFFFEC78, `FDC_FMT_SDEC1, 16'hFFCE);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UDEC2, 32'h0000C44A, `FDC_FMT_UDEC2, 16'h13A1);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SDEC2, 32'hFFFEB27C, `FDC_FMT_SDEC2, 16'hDEA6);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UDEC3, 32'h00000069, `FDC_FMT_UDEC3, 16'h0069);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SDEC3, 32'hFFFFFB2E, `FDC_FMT_SDEC3, 16'hFB2E);
  endtask : t_fixed

  // Half steps round away from zero; out-of-range clips at the word limits
  task automatic t_round_sat();
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UDEC1, 32'h00000096, `FDC_FMT_UDEC1, 16'h0002);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UDEC1, 32'h00000095, `FDC_FMT_UDEC1, 16'h0001);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SDEC1, 32'hFFFFFF6A, `FDC_FMT_SDEC1, 16'hFFFE);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SINT, 32'h01F3FC18, `FDC_FMT_SINT, `FDC_SINT_MAX);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SINT, 32'h02625A00, `FDC_FMT_SINT, `FDC_SINT_MAX);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SINT, 32'hFD9DA600, `FDC_FMT_SINT, `FDC_SINT_MIN);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UINT, 32'h042C1D80, `FDC_FMT_UINT, `FDC_UINT_MAX);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UINT, 32'hFFFFEC78, `FDC_FMT_UINT, `FDC_UINT_MIN);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_UDEC1, 32'hFFFFFF6A, `FDC_FMT_UDEC1, `FDC_UINT_MIN);
    enc(1'b0, 7'h00, 2'h0, `FDC_FMT_SDEC2, 32'hFFF0BDC0, `FDC_FMT_SDEC2, `FDC_SINT_MIN);
    enc(1'b0, 7'h00, 2'h0, 7'h09, 32'h00001234, `FDC_FMT_NONE, 16'h0000);
  endtask : t_round_sat

  task automatic t_codes();
    enc(1'b1, `FDC_ALARM2_OUTPUT_FREQ_CODE, 2'h0, 7'h00, 32'h00001234, `FDC_FMT_FREQ, 16'h1234);
    enc(1'b1, `FDC_ALARM3_OUTPUT_FREQ_CODE, 2'h1, 7'h00, 32'h00004321, `FDC_FMT_FREQ, 16'h4321);
    for (int k = 0; k < 4; k++)
      enc(1'b1, `FDC_MOTOR1_RUNTIME_CODE + k[6:0], 2'h0, 7'h00, 32'h0000ABC0 + k, `FDC_FMT_MOTOR,
          16'hABC0 + k[15:0]);
    for (int k = 0; k < 3; k++)
      enc(1'b1, `FDC_MOTOR2_START_COUNT_CODE + k[6:0], 2'h0, 7'h00, 32'h00008000 + k, `FDC_FMT_MOTOR,
          16'h8000 + k[15:0]);
    // Upper and lower halves of the three position counts
    for (int k = 0; k < 3; k++) begin
      enc(1'b1, `FDC_CURRENT_POS_UPPER_CODE + 7'(2 * k), 2'h0, 7'h00, 32'h9876A5C3, `FDC_FMT_POS_UPPER,
          16'h9876);
      enc(1'b1, `FDC_CURRENT_POS_UPPER_CODE + 7'(2 * k) + `FDC_POS_LOWER_OFS, 2'h0, 7'h00, 32'h9876A5C3,
          `FDC_FMT_UINT, 16'hA5C3);
    end
    // Alarm current format follows the protocol path
    for (int p = 0; p < 3; p++) begin
      enc(1'b1, `FDC_ALARM2_OUTPUT_CUR_CODE, p[1:0], 7'h00, 32'h00000555,
          (p == 1) ? `FDC_FMT_CUR_RTU : `FDC_FMT_CUR, 16'h0555);
      enc(1'b1, `FDC_ALARM3_OUTPUT_CUR_CODE, p[1:0], 7'h00, 32'h00000AAA,
          (p == 1) ? `FDC_FMT_CUR_RTU : `FDC_FMT_CUR, 16'h0AAA);
    end
    enc(1'b1, 7'h02, 2'h0, 7'h00, 32'h00001234, `FDC_FMT_NONE, 16'h0000);
  endtask : t_codes

  task automatic t_decode();
    dcd(16'hFB2E, `FDC_FMT_SDEC3, 32'hFFFFFB2E, 1'b0);
    dcd(16'h13A1, `FDC_FMT_UDEC2, 32'h0000C44A, 1'b0);
    dcd(16'h00C8, `FDC_FMT_UINT, 32'h00030D40, 1'b0);
    dcd(16'hFFEC, `FDC_FMT_SINT, 32'hFFFFB1E0, 1'b0);
    dcd(16'h1234, 7'h0B, 32'h00001234, 1'b1);
    rx.valid = 1'b0;
    rx.data = 8'hCB;
  endtask : t_decode

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check({30'h0, req_ready, tx_valid}, 32'h2);
    check({31'h0, resp.valid}, 32'h0);
    t_int();
    t_fixed();
    t_round_sat();
    t_codes();
    t_decode();
    @(negedge sys_clk);
    report_and_stop();
  end
endmodule : frame_data_word_codec_tb_top
